// ===== verilog/adcpm_top.sv
// Power-mode and power-on sequencing of the serial converter
`timescale 1ns/10ps
`default_nettype none

module adcpm_top #(
	parameter int POR_CYCLES = adcpm_pkg::POR_CYC
) (
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire adcpm_pkg::adcpm_link_in_t  link_in,
	output var  adcpm_pkg::adcpm_link_out_t link_out,
	input  wire logic [1:0]                 shutdown_pin,
	input  wire logic [9:0]                 sample_code,
	input  wire logic [3:0]                 reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [31:0]                     reg_rdata
);

	adcpm_pkg::adcpm_state_t st_ff;
	adcpm_pkg::adcpm_state_t nxt_st;
	adcpm_pkg::adcpm_state_t rest_st;

	logic        sclk_q_ff;
	logic [14:0] por_cnt_ff;
	logic [7:0]  ctrl_sh_ff;
	logic [2:0]  bit_cnt_ff;
	logic [1:0]  mode_ff;
	logic        clk_ext_ff;
	logic        run_ext_ff;
	logic        strobe_ff;
	logic [15:0] dout_sh_ff;
	logic        valid_ff;
	logic [9:0]  result_ff;
	logic [10:0] ref_cnt_ff;
	logic        ref_rdy_ff;
	logic        ext_ref_ff;
	logic [31:0] rdata_ff;

	wire         sclk_rise;
	wire         sclk_fall;
	wire         cs_act;
	wire         din;
	wire         pin_off;
	wire  [1:0]  comp_sel;
	wire         por_done;
	wire         awake_idle;
	wire         start_bit;
	wire         ctrl_shift;
	wire         byte_done;
	wire         conv_go;
	wire         run_ext;
	wire         sar_busy;
	wire         sar_done;
	wire  [9:0]  sar_result;
	wire         sel_status;
	wire         sel_result;
	wire         sel_ctrl;
	wire  [31:0] status_w;
	wire  [31:0] rd_mux;

	// ------------------------------------------------------------
	// Link pins and shutdown decode
	// ------------------------------------------------------------
	assign din       = link_in.din;
	assign cs_act    = ~link_in.cs_n;
	assign sclk_rise = link_in.sclk & ~sclk_q_ff;
	assign sclk_fall = ~link_in.sclk & sclk_q_ff;
	assign pin_off   = shutdown_pin == adcpm_pkg::SHUT_LOW; // [R22]
	assign comp_sel  = pin_off ? adcpm_pkg::COMP_OFF : // [R5]
		(shutdown_pin == adcpm_pkg::SHUT_HIGH ? adcpm_pkg::COMP_INT : adcpm_pkg::COMP_EXT);

	always_ff @(posedge mclk) begin
		if (srst) begin
			sclk_q_ff <= 1'b0;
		end else begin
			sclk_q_ff <= link_in.sclk;
		end
	end

	// ------------------------------------------------------------
	// Power-on reset timer
	// ------------------------------------------------------------
	assign por_done = por_cnt_ff == 15'(POR_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (srst) begin
			por_cnt_ff <= 15'h0000;
		end else if (st_ff == adcpm_pkg::ST_POR) begin
			por_cnt_ff <= por_cnt_ff + 15'h0001; // [R1]
		end
	end

	// ------------------------------------------------------------
	// Control byte capture
	// ------------------------------------------------------------
	assign awake_idle = st_ff == adcpm_pkg::ST_IDLE || st_ff == adcpm_pkg::ST_SWPD;
	assign start_bit  = sclk_rise & cs_act & din & awake_idle; // [R3] [R13]
	assign ctrl_shift = sclk_rise & cs_act & (st_ff == adcpm_pkg::ST_CTRL);
	assign byte_done  = ctrl_shift & (bit_cnt_ff == 3'h7);
	assign conv_go    = sclk_fall & cs_act & (st_ff == adcpm_pkg::ST_ARM); // [R21]
	assign run_ext    = ctrl_sh_ff[1] ? ctrl_sh_ff[0] : clk_ext_ff; // [R11]

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_sh_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
		end else if (start_bit) begin
			ctrl_sh_ff <= 8'h01;
			bit_cnt_ff <= 3'h1;
		end else if (ctrl_shift) begin
			ctrl_sh_ff <= {ctrl_sh_ff[6:0], din};
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_ff    <= adcpm_pkg::PM_INT; // [R2]
			clk_ext_ff <= 1'b0;
			run_ext_ff <= 1'b0;
		end else if (conv_go) begin
			mode_ff    <= ctrl_sh_ff[1:0]; // [R8] [R13]
			clk_ext_ff <= run_ext;
			run_ext_ff <= run_ext;
		end
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	assign rest_st = mode_ff[1] ? adcpm_pkg::ST_IDLE : adcpm_pkg::ST_SWPD;

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			adcpm_pkg::ST_POR: begin
				if (por_done) begin
					nxt_st = adcpm_pkg::ST_IDLE; // [R1] [R2]
				end
			end
			adcpm_pkg::ST_IDLE, adcpm_pkg::ST_SWPD: begin
				if (start_bit) begin
					nxt_st = adcpm_pkg::ST_CTRL; // [R13]
				end
			end
			adcpm_pkg::ST_CTRL: begin
				if (!cs_act) begin
					nxt_st = rest_st;
				end else if (byte_done) begin
					nxt_st = adcpm_pkg::ST_ARM;
				end
			end
			adcpm_pkg::ST_ARM: begin
				if (!cs_act) begin
					nxt_st = rest_st;
				end else if (sclk_fall) begin
					nxt_st = adcpm_pkg::ST_CONV; // [R21]
				end
			end
			adcpm_pkg::ST_CONV: begin
				if (sar_done) begin
					nxt_st = rest_st; // [R11] [R14]
				end
			end
			adcpm_pkg::ST_HWSD: begin
				if (!pin_off) begin
					nxt_st = rest_st;
				end
			end
		endcase
		if (pin_off && st_ff != adcpm_pkg::ST_POR) begin
			nxt_st = adcpm_pkg::ST_HWSD; // [R9] [R16]
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_ff <= adcpm_pkg::ST_POR;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Converter core
	// ------------------------------------------------------------
	adcpm_sar u_sar (
		.mclk        (mclk),
		.srst        (srst),
		.start       (conv_go),
		.ext_clk     (run_ext),
		.sclk_fall   (sclk_fall),
		.abort       (pin_off), // [R16]
		.sample_code (sample_code),
		.busy        (sar_busy),
		.done        (sar_done),
		.result      (sar_result)
	);

	// ------------------------------------------------------------
	// Strobe and data output
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			strobe_ff <= 1'b1; // [R2]
		end else if (conv_go) begin
			strobe_ff <= run_ext;
		end else if (run_ext_ff && sclk_fall) begin
			strobe_ff <= 1'b0;
		end else if (!run_ext_ff && (sar_done || pin_off)) begin
			strobe_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dout_sh_ff <= 16'h0000; // [R4]
			valid_ff   <= 1'b0;
			result_ff  <= 10'h000;
		end else if (sar_done) begin
			dout_sh_ff <= {sar_result, 6'h00};
			valid_ff   <= 1'b1;
			result_ff  <= sar_result;
		end else if (sclk_fall && cs_act) begin
			dout_sh_ff <= {dout_sh_ff[14:0], 1'b0}; // [R10] [R12]
		end
	end

	assign link_out = '{
		dout:      dout_sh_ff[15],
		dout_oe:   cs_act,
		strobe:    strobe_ff,
		strobe_oe: ~run_ext_ff | cs_act
	};

	// ------------------------------------------------------------
	// Reference wake-up
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			ref_rdy_ff <= 1'b1;
			ref_cnt_ff <= 11'h000;
		end else if (pin_off) begin
			ref_rdy_ff <= ext_ref_ff; // [R17]
			ref_cnt_ff <= 11'h000;
		end else if (!ref_rdy_ff) begin
			ref_cnt_ff <= ref_cnt_ff + 11'h001;
			ref_rdy_ff <= ref_cnt_ff == 11'(adcpm_pkg::WAKE_CYC - 1);
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	assign sel_status = reg_addr == adcpm_pkg::REG_STATUS;
	assign sel_result = reg_addr == adcpm_pkg::REG_RESULT;
	assign sel_ctrl   = reg_addr == adcpm_pkg::REG_CTRL;
	assign status_w   = {17'h00000, st_ff == adcpm_pkg::ST_POR, ref_rdy_ff, valid_ff,
		comp_sel, clk_ext_ff, mode_ff, st_ff};
	assign rd_mux     = sel_status ? status_w :
		sel_result ? {22'h000000, result_ff} :
		sel_ctrl ? {31'h00000000, ext_ref_ff} : 32'h00000000;

	always_ff @(posedge mclk) begin
		if (srst) begin
			ext_ref_ff <= adcpm_pkg::CTRL_RESET;
		end else if (reg_wr && sel_ctrl) begin
			ext_ref_ff <= reg_wdata[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || !reg_rd) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= rd_mux;
		end
	end

	assign reg_rdata = rdata_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	a_por_no_start: assert property ( // [R1]
		st_ff == adcpm_pkg::ST_POR && !por_done |=> st_ff == adcpm_pkg::ST_POR && !sar_busy)
		else $error("power-on reset left early");

	a_reset_state: assert property ( // [R2]
		$past(srst) |-> strobe_ff && mode_ff == adcpm_pkg::PM_INT)
		else $error("wrong state after reset");

	a_start_bit_taken: assert property ( // [R3]
		start_bit && !pin_off |=> st_ff == adcpm_pkg::ST_CTRL && bit_cnt_ff == 3'h1)
		else $error("start bit not taken");

	a_dout_zero: assert property ( // [R4]
		!valid_ff |-> !link_out.dout)
		else $error("data before first conversion");

	a_comp_decode: assert property ( // [R5]
		shutdown_pin == adcpm_pkg::SHUT_HIGH |-> comp_sel == adcpm_pkg::COMP_INT)
		else $error("compensation decode wrong");

	a_mode_load: assert property ( // [R8]
		conv_go |=> mode_ff == $past(ctrl_sh_ff[1:0]))
		else $error("power bits not loaded");

	a_hw_shutdown: assert property ( // [R9]
		pin_off && st_ff != adcpm_pkg::ST_POR |=> st_ff == adcpm_pkg::ST_HWSD && !sar_busy)
		else $error("shutdown pin ignored");

	a_pd_waits: assert property ( // [R11]
		st_ff == adcpm_pkg::ST_CONV && !sar_done && !pin_off |=> st_ff == adcpm_pkg::ST_CONV)
		else $error("conversion left early");

	a_stay_up: assert property ( // [R14]
		st_ff == adcpm_pkg::ST_CONV && sar_done && !pin_off |=>
		st_ff == (mode_ff[1] ? adcpm_pkg::ST_IDLE : adcpm_pkg::ST_SWPD))
		else $error("wrong state after conversion");

	a_conv_begin: assert property ( // [R21]
		st_ff == adcpm_pkg::ST_ARM && conv_go && !pin_off |=> ##1 sar_busy)
		else $error("conversion did not begin");

endmodule : adcpm_top

`default_nettype wire

// ===== verilog/adcpm_pkg.sv
// Shared constants and types for the converter power-mode block
//
// How it works
// [R1] Hold internal reset 100us; no conversions
// [R2] Leave reset in internal clock mode, strobe high
// [R3] First one on data input is start bit
// [R4] Data output shifts zeros before first conversion
// [R5] Shutdown pin: high internal, float external, low off
// [R6] Host: internal compensation needs external clock <=400kHz
// [R7] Host: serial clock at least 100kHz
// [R8] Power bits pick ext, int, fast, full
// [R9] Shutdown pin low forces full power-down always; code ignores it until power-on reset ends
// [R10] Serial shifting continues in software power-down
// [R11] Software power-down waits for conversion end
// [R12] Result still readable after software power-down
// [R13] Start bit wakes; new byte sets mode
// [R14] High power bit one stays up, zero sleeps
// [R15] Host: wait 5us after fast wake, internal
// [R16] Shutdown pin low aborts conversion at once
// [R17] External reference kept on: no wake delay
// [R18] Host: wait 20ms, discharged external capacitor
// [R19] Host: wait 50us after fast wake, external
// [R20] Host: settle 2ms in fast power-down
// [R21] Conversion starts on fall after eighth bit
// [R22] Shutdown pin arrives two-bit encoded, sampled continuously

package adcpm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int POR_TIME_US  = 100;
	localparam int POR_CYC      = POR_TIME_US * CLK_MHZ;
	localparam int CONV_TIME_NS = 10000;
	localparam int SAR_STEPS    = 12;
	localparam int SAR_BITS     = 10;
	localparam int STEP_CYC     = CONV_TIME_NS * CLK_MHZ / 1000 / SAR_STEPS;
	localparam int WAKE_TIME_NS = 5000;
	localparam int WAKE_CYC     = WAKE_TIME_NS * CLK_MHZ / 1000;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	localparam logic [3:0]  REG_STATUS = 4'h0;
	localparam logic [3:0]  REG_RESULT = 4'h4;
	localparam logic [3:0]  REG_CTRL   = 4'h8;
	localparam logic        CTRL_RESET = 1'h0;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SHUT_LOW   = 2'h0;
	localparam logic [1:0] SHUT_FLOAT = 2'h1;
	localparam logic [1:0] SHUT_HIGH  = 2'h3;
	localparam logic [1:0] PM_EXT     = 2'h3;
	localparam logic [1:0] PM_INT     = 2'h2;
	localparam logic [1:0] PM_FAST    = 2'h1;
	localparam logic [1:0] PM_FULL    = 2'h0;
	localparam logic [1:0] COMP_INT   = 2'h1;
	localparam logic [1:0] COMP_EXT   = 2'h2;
	localparam logic [1:0] COMP_OFF   = 2'h0;

	typedef enum logic [6:0] {
		ST_POR  = 7'h01,
		ST_IDLE = 7'h02,
		ST_CTRL = 7'h04,
		ST_ARM  = 7'h08,
		ST_CONV = 7'h10,
		ST_SWPD = 7'h20,
		ST_HWSD = 7'h40
	} adcpm_state_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
	} adcpm_link_in_t;

	typedef struct packed {
		logic dout;
		logic dout_oe;
		logic strobe;
		logic strobe_oe;
	} adcpm_link_out_t;

endpackage : adcpm_pkg

// ===== verilog/adcpm_sar.sv
// Successive-approximation sequencer, internal or serial-clock paced
`timescale 1ns/10ps
`default_nettype none

module adcpm_sar (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic       ext_clk,
	input  wire logic       sclk_fall,
	input  wire logic       abort,
	input  wire logic [9:0] sample_code,
	output logic            busy,
	output logic            done,
	output logic [9:0]      result
);

	logic [3:0]  step_ff;
	logic [7:0]  tick_ff;
	logic        busy_ff;
	logic        done_ff;
	logic        ext_ff;
	logic [9:0]  sar_ff;
	wire         tick_end;
	wire         step_en;
	wire         last_step;
	wire         bit_step;
	wire  [9:0]  trial;

	// ------------------------------------------------------------
	// Step pacing
	// ------------------------------------------------------------
	assign tick_end  = tick_ff == 8'(adcpm_pkg::STEP_CYC - 1);
	assign step_en   = busy_ff & (ext_ff ? sclk_fall : tick_end);
	assign last_step = step_ff == 4'(adcpm_pkg::SAR_STEPS - 1);
	assign bit_step  = step_ff < 4'(adcpm_pkg::SAR_BITS);
	assign trial     = sar_ff | (10'h200 >> step_ff);

	always_ff @(posedge mclk) begin
		if (srst || !busy_ff || tick_end) begin
			tick_ff <= 8'h00;
		end else begin
			tick_ff <= tick_ff + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		done_ff <= 1'b0;
		if (srst) begin
			busy_ff <= 1'b0;
			step_ff <= 4'h0;
			sar_ff  <= 10'h000;
			ext_ff  <= 1'b0;
		end else if (abort) begin
			busy_ff <= 1'b0; // [R16]
		end else if (start) begin
			busy_ff <= 1'b1; // [R21]
			step_ff <= 4'h0;
			sar_ff  <= 10'h000;
			ext_ff  <= ext_clk;
		end else if (step_en) begin
			if (bit_step && trial <= sample_code) begin
				sar_ff <= trial;
			end
			step_ff <= step_ff + 4'h1;
			if (last_step) begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
		end
	end

	assign busy   = busy_ff;
	assign done   = done_ff;
	assign result = sar_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_sar_starts: assert property (@(posedge mclk) disable iff (srst) // [R21]
		start && !abort |=> busy_ff && step_ff == 4'h0)
		else $error("conversion did not start");

	a_sar_aborts: assert property (@(posedge mclk) disable iff (srst) // [R16]
		abort |=> !busy_ff && !done_ff)
		else $error("conversion not aborted");

endmodule : adcpm_sar

`default_nettype wire

// ===== tb/adcpm_host.sv
// Serial host model: clock master of the control and data link
`timescale 1ns/10ps
`default_nettype none

module adcpm_host (
	input  wire logic                       mclk,
	output var  adcpm_pkg::adcpm_link_in_t  link_in,
	input  wire adcpm_pkg::adcpm_link_out_t link_out
);
	// ------------------------------------------------------------
	// Link timing
	// ------------------------------------------------------------
	// 127 mclk a period, about 2MHz: above the 100kHz floor
	int half_cyc = 63;
	// Wake gap from fast power-down with external compensation, 50us
	localparam int FAST_EXT_CYC = 50 * adcpm_pkg::CLK_MHZ;
	// Shutdowns here last only cycles, so no 20ms or 2ms settle applies
	// Power bits of the last control byte sent
	logic [1:0] last_pb = 2'h2;

	// Serial clock stands low outside frames
	initial link_in = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};

	task automatic sel(input logic on);
		@(posedge mclk);
		link_in.cs_n <= ~on;
	endtask : sel

	// One byte MSB first; dout taken at each rising serial clock
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (i == 6 && tx[7] && last_pb == 2'h1) begin
				repeat (FAST_EXT_CYC) @(posedge mclk);
			end
			@(posedge mclk);
			link_in.din <= tx[i];
			repeat (half_cyc) @(posedge mclk);
			link_in.sclk <= 1'b1;
			rx[i] = link_out.dout;
			repeat (half_cyc) @(posedge mclk);
			link_in.sclk <= 1'b0;
		end
		@(posedge mclk);
		link_in.din <= 1'b0;
		if (tx[7]) begin
			last_pb = tx[1:0];
		end
	endtask : xfer
endmodule : adcpm_host
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter power-mode block
`timescale 1ns/10ps
`default_nettype none

module tb;
	typedef struct packed {
		logic [1:0] pb;
		logic [9:0] code;
		logic       dchk;
	} adcpm_row_t;

	localparam int POR_N = 20;
	logic                       mclk         = 1'b0;
	logic                       srst         = 1'b1;
	logic [1:0]                 shutdown_pin = 2'h1;
	logic [9:0]                 sample_code  = 10'h0;
	logic [3:0]                 reg_addr     = 4'h0;
	logic [31:0]                reg_wdata    = 32'h0;
	logic                       reg_wr       = 1'b0;
	logic                       reg_rd       = 1'b0;
	logic [31:0]                reg_rdata;
	adcpm_pkg::adcpm_link_in_t  link_in;
	adcpm_pkg::adcpm_link_out_t link_out;
	int                         err_total    = 0;
	int                         num_checks   = 0;
	logic [31:0]                rd_v;
	logic [7:0]                 rx_a;
	logic [7:0]                 rx_b;
	logic                       ext_used;
	// Power bits, sample, dout checked
	adcpm_row_t                 rows [4]     = '{'{2'h3, 10'h2a5, 1'b0},
		'{2'h1, 10'h15a, 1'b0}, '{2'h2, 10'h3ff, 1'b1}, '{2'h0, 10'h001, 1'b1}};

	always #2 mclk = ~mclk;

	adcpm_top #(.POR_CYCLES(POR_N)) dut_u (
		.mclk         (mclk),
		.srst         (srst),
		.link_in      (link_in),
		.link_out     (link_out),
		.shutdown_pin (shutdown_pin),
		.sample_code  (sample_code),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata)
	);

	adcpm_host host_u (.mclk(mclk), .link_in(link_in), .link_out(link_out));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		d = reg_rdata;
	endtask : rd

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (80000) @(posedge mclk);
		err_total++;
		close_out();
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk);
		chk("strobe_rst", 32'h1, link_out.strobe);
		srst <= 1'b0;
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("por_state", 32'h01, rd_v[6:0]);
		chk("por_flag", 32'h1, rd_v[14]);
		chk("por_mode", 32'h2, rd_v[8:7]);
		// No request before power-on reset ends
		repeat (POR_N + 4) @(posedge mclk);
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("idle_state", 32'h02, rd_v[6:0]);
		wr(adcpm_pkg::REG_CTRL, 32'h1);
		rd(adcpm_pkg::REG_CTRL, rd_v);
		chk("ctrl_rw", 32'h1, rd_v[0]);
		rd(4'hc, rd_v);
		chk("unmapped", 32'h0, rd_v);
		// Float pin keeps external compensation, so a fast clock is allowed
		host_u.sel(1'b1);
		host_u.xfer(8'h00, rx_a);
		host_u.xfer(8'h00, rx_b);
		chk("zeros_first", 32'h0, {rx_a, rx_b});
		ext_used = 1'b0;
		foreach (rows[i]) begin
			sample_code <= rows[i].code;
			if (rows[i].pb[1]) ext_used = rows[i].pb[0];
			host_u.xfer({6'b100000, rows[i].pb}, rx_a);
			repeat (8) @(posedge mclk);
			for (int n = 0; n < 4000 && link_out.strobe !== 1'b1; n++) @(posedge mclk);
			chk("strobe_done", 32'h1, link_out.strobe);
			host_u.xfer(8'h00, rx_a);
			host_u.xfer(8'h00, rx_b);
			if (rows[i].dchk) chk("dout", {rows[i].code, 6'h0}, {rx_a, rx_b});
			rd(adcpm_pkg::REG_RESULT, rd_v);
			chk("result", rows[i].code, rd_v[9:0]);
			rd(adcpm_pkg::REG_STATUS, rd_v);
			chk("mode", rows[i].pb, rd_v[8:7]);
			chk("clk_used", ext_used, rd_v[9]);
			chk("after", rows[i].pb[1] ? 32'h02 : 32'h20, rd_v[6:0]);
		end
		// Pin decode: high, spare code, float, low; no frames while high
		for (int k = 3; k >= 0; k--) begin
			shutdown_pin <= k[1:0];
			repeat (4) @(posedge mclk);
			rd(adcpm_pkg::REG_STATUS, rd_v);
			chk("comp", k == 3 ? 32'h1 : (k == 0 ? 32'h0 : 32'h2), rd_v[11:10]);
		end
		host_u.xfer(8'h83, rx_a);
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("hw_off", 32'h40, rd_v[6:0]);
		chk("ref_kept", 32'h1, rd_v[13]);
		shutdown_pin <= 2'h1;
		repeat (4) @(posedge mclk);
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("wake_state", 32'h20, rd_v[6:0]);
		chk("ref_ready", 32'h1, rd_v[13]);
		// Abort an internal-clock conversion during its first step
		sample_code <= 10'h2aa;
		host_u.xfer(8'h82, rx_a);
		repeat (100) @(posedge mclk);
		chk("conv_busy", 32'h0, link_out.strobe);
		shutdown_pin <= 2'h0;
		repeat (3) @(posedge mclk);
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("abort_state", 32'h40, rd_v[6:0]);
		chk("abort_strobe", 32'h1, link_out.strobe);
		rd(adcpm_pkg::REG_RESULT, rd_v);
		chk("abort_result", 32'h001, rd_v[9:0]);
		shutdown_pin <= 2'h1;
		// Second reset in mid-run
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd(adcpm_pkg::REG_STATUS, rd_v);
		chk("rst2_state", 32'h01, rd_v[6:0]);
		chk("rst2_strobe", 32'h1, link_out.strobe);
		repeat (POR_N + 4) @(posedge mclk);
		host_u.xfer(8'h00, rx_a);
		host_u.xfer(8'h00, rx_b);
		chk("rst2_zeros", 32'h0, {rx_a, rx_b});
		host_u.sel(1'b0);
		@(posedge mclk);
		chk("dout_oe_off", 32'h0, link_out.dout_oe);
		chk("strobe_oe_int", 32'h1, link_out.strobe_oe);
		close_out();
	end
endmodule : tb
`default_nettype wire
